// ---- core/acw_axis.sv ----
// Purpose: Axis configuration word decode and its drive/feedback effects
// Assumes: AXI4-Lite slave, one clock, synchronous inputs
// Notes:   Staged config only takes effect on the apply command
// How it works
// - Configuration word is 16 bits, resets zero, bit 1 is the MSB.
// - Bits 1-4 give recirculation count; zero means start-stop transducer.
// - Subtract 2700 counts per recirculation from the raw transducer count.
// - Bit 10 inverts drive output; reported drive is the negation.
// - Bit 11 allows only positive drive before the bit 10 inversion, never negative.
// - Absolute mode: move completion enters open loop with null drive.
// - Absolute mode: apply command enters open loop with null drive.
// - On link loss, bit 12 finishes the move, else halts at once.
// - Bit 13 nulls drive, follows target, clears transducer errors.
// - Bits 14/15 divide counts by four, two, or eight together.
// - Integrator limit 20% or 80% by bit 16; clamp sets windup.
// - Written config takes effect only on the apply command; the target on go.
// - Go starts a move toward the command; halt stops the axis.
// - Only bits 1-4 and 10-16 have any effect.
module acw_axis #(
  parameter int unsigned W = 24,
  parameter int unsigned GAIN_SHIFT = 2
) (
  input  wire logic          i_clk,
  input  wire logic          i_rst,
  input  wire logic [W-1:0]  i_raw_count,
  input  wire logic          i_xdcr_fault,
  input  wire logic          i_link_lost,
  output logic      [W-1:0]  o_drive,
  output logic               o_irq,
  input  wire logic [7:0]    s_axi_awaddr,
  input  wire logic          s_axi_awvalid,
  output logic               s_axi_awready,
  input  wire logic [31:0]   s_axi_wdata,
  input  wire logic [3:0]    s_axi_wstrb,
  input  wire logic          s_axi_wvalid,
  output logic               s_axi_wready,
  output logic [1:0]         s_axi_bresp,
  output logic               s_axi_bvalid,
  input  wire logic          s_axi_bready,
  input  wire logic [7:0]    s_axi_araddr,
  input  wire logic          s_axi_arvalid,
  output logic               s_axi_arready,
  output logic [31:0]        s_axi_rdata,
  output logic [1:0]         s_axi_rresp,
  output logic               s_axi_rvalid,
  input  wire logic          s_axi_rready
);
  // ****************************************
  // Declarations
  // ****************************************
  logic [15:0]             cfg_stage_reg;
  logic [15:0]             cfg_reg;
  logic [W-1:0]            target_reg;
  logic [W-1:0]            target_stage_reg;
  logic [acw_pkg::ST_W-1:0] status_reg;
  logic [acw_pkg::ST_W-1:0] irq_en_reg;
  logic [acw_pkg::ST_W-1:0] events;
  logic [acw_pkg::ST_W-1:0] clr_bits;
  acw_pkg::acw_axis_t      state_reg;
  acw_pkg::acw_axis_t      state_next;
  logic [W-1:0]            loc;
  logic signed [W-1:0]     err;
  logic signed [W-1:0]     acc;
  logic                    windup;
  logic signed [W+1:0]     pid;
  logic signed [W-1:0]     drv_cmd;
  logic signed [W-1:0]     drv_out;
  logic signed [W-1:0]     drv_report_reg;
  logic                    aw_hold;
  logic                    w_hold;
  logic [7:0]              aw_addr_reg;
  logic [31:0]             w_data_reg;
  logic [3:0]              w_strb_reg;
  logic                    wr_fire;
  logic                    apply_p;
  logic                    go_p;
  logic                    halt_p;
  logic                    move_done;
  logic                    link_prev_reg;
  logic                    link_fall;
  logic                    wr_ok;
  localparam logic signed [W+1:0] DRV_MAX = (W+2)'((1 << (W-1)) - 1);

  // ****************************************
  // AXI4-Lite write
  // ****************************************
  assign wr_fire = aw_hold && w_hold && !s_axi_bvalid;
  assign wr_ok   = (aw_addr_reg <= acw_pkg::OFF_INTEG) && (aw_addr_reg[1:0] == 2'b00);

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      aw_hold       <= 1'b0;
      w_hold        <= 1'b0;
      aw_addr_reg   <= '0;
      w_data_reg    <= '0;
      w_strb_reg    <= '0;
      s_axi_awready <= 1'b1;
      s_axi_wready  <= 1'b1;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= acw_pkg::RESP_OKAY;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_hold       <= 1'b1;
        aw_addr_reg   <= s_axi_awaddr;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_hold       <= 1'b1;
        w_data_reg   <= s_axi_wdata;
        w_strb_reg   <= s_axi_wstrb;
        s_axi_wready <= 1'b0;
      end
      if (wr_fire) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= wr_ok ? acw_pkg::RESP_OKAY : acw_pkg::RESP_SLVERR;
        aw_hold      <= 1'b0;
        w_hold       <= 1'b0;
      end
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid  <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready  <= 1'b1;
      end
    end
  end

  // Command pulses on a write of the command word with its bit set; byte strobes are ignored
  assign apply_p = wr_fire && aw_addr_reg == acw_pkg::OFF_CMD && w_data_reg[acw_pkg::CMD_APPLY];
  assign go_p    = wr_fire && aw_addr_reg == acw_pkg::OFF_CMD && w_data_reg[acw_pkg::CMD_GO];
  assign halt_p  = wr_fire && aw_addr_reg == acw_pkg::OFF_CMD && w_data_reg[acw_pkg::CMD_HALT];
  // Staging registers; byte strobes on the low two lanes for the config word only
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      cfg_stage_reg    <= acw_pkg::CFG_RESET;
      target_stage_reg <= '0;
      irq_en_reg       <= '0;
    end else if (wr_fire) begin
      case (aw_addr_reg)
        acw_pkg::OFF_CFG: begin
          if (w_strb_reg[0]) cfg_stage_reg[7:0]  <= w_data_reg[7:0];
          if (w_strb_reg[1]) cfg_stage_reg[15:8] <= w_data_reg[15:8];
        end
        acw_pkg::OFF_TARGET: begin
          target_stage_reg <= w_data_reg[W-1:0];
        end
        acw_pkg::OFF_IRQ_EN: begin
          irq_en_reg <= w_data_reg[acw_pkg::ST_W-1:0];
        end
        default: begin
        end
      endcase
    end
  end

  // Active config moves only on apply, the target only on go; unused bits are masked off
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      cfg_reg <= acw_pkg::CFG_RESET;
    end else if (apply_p) begin
      cfg_reg <= cfg_stage_reg & acw_pkg::CFG_MASK;
    end
  end

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      target_reg <= '0;
    end else if (go_p) begin
      target_reg <= target_stage_reg;
    end
  end

  // ****************************************
  // Feedback and integrator
  // ****************************************
  acw_feedback #(.W(W)) u_fb (
    .i_clk    (i_clk),
    .i_rst    (i_rst),
    .i_cfg    (cfg_reg),
    .i_raw    (i_raw_count),
    .i_target (target_reg),
    .o_loc    (loc)
  );

  assign err = $signed(target_reg - loc);

  acw_integ #(.W(W)) u_int (
    .i_clk    (i_clk),
    .i_rst    (i_rst),
    .i_clear  (state_reg != acw_pkg::ACW_MOVE),
    .i_hi_lim (cfg_reg[acw_pkg::ILIM_BIT]),
    .i_err    (err),
    .o_acc    (acc),
    .o_windup (windup)
  );

  // ****************************************
  // Axis state
  // ****************************************
  assign move_done = (err == '0);
  assign link_fall = i_link_lost && !link_prev_reg;

  always_comb begin
    state_next = state_reg;
    case (state_reg)
      acw_pkg::ACW_IDLE: begin
        if (go_p) state_next = acw_pkg::ACW_MOVE;
      end
      acw_pkg::ACW_MOVE: begin
        if (halt_p) begin
          state_next = acw_pkg::ACW_IDLE;
        end else if (link_fall && !cfg_reg[acw_pkg::CONT_BIT]) begin
          state_next = acw_pkg::ACW_IDLE;
        end else if (move_done && cfg_reg[acw_pkg::ABS_BIT]) begin
          state_next = acw_pkg::ACW_OPEN;
        end
      end
      acw_pkg::ACW_OPEN: begin
        if (go_p) state_next = acw_pkg::ACW_MOVE;
      end
      default: state_next = acw_pkg::ACW_IDLE;
    endcase
    // Apply in absolute mode wins over anything else
    if (apply_p && cfg_stage_reg[acw_pkg::ABS_BIT]) state_next = acw_pkg::ACW_OPEN;
  end

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      state_reg     <= acw_pkg::ACW_IDLE;
      link_prev_reg <= 1'b0;
    end else begin
      state_reg     <= state_next;
      link_prev_reg <= i_link_lost;
    end
  end

  // ****************************************
  // Drive path
  // ****************************************
  always_comb begin
    pid     = ((W+2)'(err) >>> GAIN_SHIFT) + (W+2)'(acc);
    // Saturate so a large error never wraps into reverse drive
    if (pid > DRV_MAX) pid = DRV_MAX;
    if (pid < -DRV_MAX) pid = -DRV_MAX;
    drv_cmd = (state_reg == acw_pkg::ACW_MOVE) ? W'(pid) : '0;
    if (cfg_reg[acw_pkg::ABS_BIT] && drv_cmd < 0) drv_cmd = '0;
    if (cfg_reg[acw_pkg::SIM_BIT]) drv_cmd = '0;
    drv_out = cfg_reg[acw_pkg::REV_BIT] ? -drv_cmd : drv_cmd;
  end

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      o_drive        <= '0;
      drv_report_reg <= '0;
    end else begin
      o_drive        <= drv_out;
      drv_report_reg <= drv_cmd; // Reported value is the pre-inversion drive
    end
  end

  // ****************************************
  // Status and interrupt
  // ****************************************
  always_comb begin
    events = '0;
    events[acw_pkg::ST_WINDUP]   = windup;
    events[acw_pkg::ST_DONE]     = state_reg == acw_pkg::ACW_MOVE && move_done;
    events[acw_pkg::ST_LINKLOSS] = link_fall;
    events[acw_pkg::ST_XDCR_ERR] = i_xdcr_fault && !cfg_reg[acw_pkg::SIM_BIT];
    clr_bits = '0;
    if (wr_fire && aw_addr_reg == acw_pkg::OFF_IRQ_CLR) begin
      clr_bits = w_data_reg[acw_pkg::ST_W-1:0];
    end
    if (cfg_reg[acw_pkg::SIM_BIT]) clr_bits[acw_pkg::ST_XDCR_ERR] = 1'b1;
  end

  // Set wins over a simultaneous clear
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      status_reg <= '0;
      o_irq      <= 1'b0;
    end else begin
      status_reg <= (status_reg & ~clr_bits) | events;
      o_irq      <= |(((status_reg & ~clr_bits) | events) & irq_en_reg);
    end
  end

  // ****************************************
  // AXI4-Lite read
  // ****************************************
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= '0;
      s_axi_rresp   <= acw_pkg::RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b1;
      s_axi_rresp   <= acw_pkg::RESP_OKAY;
      case (s_axi_araddr)
        acw_pkg::OFF_CFG:     s_axi_rdata <= {16'h0000, cfg_stage_reg};
        acw_pkg::OFF_CMD:     s_axi_rdata <= '0;
        acw_pkg::OFF_TARGET:  s_axi_rdata <= 32'(target_stage_reg);
        acw_pkg::OFF_ACTIVE:  s_axi_rdata <= {16'h0000, cfg_reg};
        acw_pkg::OFF_POS:     s_axi_rdata <= 32'(loc);
        acw_pkg::OFF_DRIVE:   s_axi_rdata <= 32'(drv_report_reg);
        acw_pkg::OFF_STATUS:  s_axi_rdata <= {29'h0, state_reg == acw_pkg::ACW_OPEN, 2'b00} << 4
                                             | 32'(status_reg);
        acw_pkg::OFF_IRQ_EN:  s_axi_rdata <= 32'(irq_en_reg);
        acw_pkg::OFF_IRQ_CLR: s_axi_rdata <= '0;
        acw_pkg::OFF_INTEG:   s_axi_rdata <= 32'(acc);
        default: begin
          s_axi_rdata <= '0;
          s_axi_rresp <= acw_pkg::RESP_SLVERR;
        end
      endcase
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid  <= 1'b0;
      s_axi_arready <= 1'b1;
    end
  end

  // ****************************************
  // Checks
  // ****************************************
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_rst);

  apply_gate_a: assert property (
    !apply_p |=> $stable(cfg_reg)) else $error("config changed without apply");
  apply_mask_a: assert property (
    (cfg_reg & ~acw_pkg::CFG_MASK) == '0) else $error("unused config bit active");
  abs_apply_a: assert property (
    apply_p && cfg_stage_reg[acw_pkg::ABS_BIT] |=> state_reg == acw_pkg::ACW_OPEN ##1 o_drive == '0)
    else $error("apply in absolute mode not null");
  abs_positive_a: assert property (
    cfg_reg[acw_pkg::ABS_BIT] && !cfg_reg[acw_pkg::REV_BIT] |=> !o_drive[W-1])
    else $error("negative drive in absolute mode");
  sim_null_a: assert property (
    cfg_reg[acw_pkg::SIM_BIT] && $stable(cfg_reg) |=> o_drive == '0) else $error("drive in simulate");
  rev_report_a: assert property (
    $stable(cfg_reg) && cfg_reg[acw_pkg::REV_BIT] |=> o_drive == W'(-drv_report_reg))
    else $error("reported drive not negated");
  halt_stop_a: assert property (
    halt_p && !apply_p && state_reg == acw_pkg::ACW_MOVE |=> state_reg == acw_pkg::ACW_IDLE)
    else $error("halt ignored");
  link_cont_a: assert property (
    link_fall && state_reg == acw_pkg::ACW_MOVE && cfg_reg[acw_pkg::CONT_BIT] && !halt_p
    && !apply_p && !move_done |=> state_reg == acw_pkg::ACW_MOVE) else $error("continue lost");
  abs_done_a: assert property (
    state_reg == acw_pkg::ACW_MOVE && move_done && cfg_reg[acw_pkg::ABS_BIT] && !halt_p
    && !link_fall |=> state_reg == acw_pkg::ACW_OPEN) else $error("no open loop after move");
endmodule // acw_axis

// ---- core/acw_pkg.sv ----
// Purpose: Shared constants for the axis configuration word logic
// Assumes: 25 MHz clock, AXI4-Lite register access
// Notes:   Config bit n (1 = MSB) sits at word bit 16-n
package acw_pkg;
  localparam int unsigned CFG_W        = 16;
  localparam logic [15:0] CFG_RESET    = 16'h0000;
  // Word bit positions, bit 1 of the word is index 15
  localparam int unsigned RECIRC_HI    = 15;
  localparam int unsigned RECIRC_LO    = 12;
  localparam int unsigned REV_BIT      = 6;
  localparam int unsigned ABS_BIT      = 5;
  localparam int unsigned CONT_BIT     = 4;
  localparam int unsigned SIM_BIT      = 3;
  localparam int unsigned DIV4_BIT     = 2;
  localparam int unsigned DIV2_BIT     = 1;
  localparam int unsigned ILIM_BIT     = 0;
  localparam logic [15:0] CFG_MASK     = 16'hf07f;
  localparam int unsigned RECIRC_COUNTS = 2700;
  localparam int unsigned ILIM_LO_PCT  = 20;
  localparam int unsigned ILIM_HI_PCT  = 80;
  // Register byte offsets
  localparam logic [7:0]  OFF_CFG      = 8'h00;
  localparam logic [7:0]  OFF_CMD      = 8'h04;
  localparam logic [7:0]  OFF_TARGET   = 8'h08;
  localparam logic [7:0]  OFF_ACTIVE   = 8'h0c;
  localparam logic [7:0]  OFF_POS      = 8'h10;
  localparam logic [7:0]  OFF_DRIVE    = 8'h14;
  localparam logic [7:0]  OFF_STATUS   = 8'h18;
  localparam logic [7:0]  OFF_IRQ_EN   = 8'h1c;
  localparam logic [7:0]  OFF_IRQ_CLR  = 8'h20;
  localparam logic [7:0]  OFF_INTEG    = 8'h24;
  // Command register bits
  localparam int unsigned CMD_APPLY    = 0;
  localparam int unsigned CMD_GO       = 1;
  localparam int unsigned CMD_HALT     = 2;
  // Status bits
  localparam int unsigned ST_WINDUP    = 0;
  localparam int unsigned ST_DONE      = 1;
  localparam int unsigned ST_LINKLOSS  = 2;
  localparam int unsigned ST_XDCR_ERR  = 3;
  localparam int unsigned ST_W         = 4;
  localparam logic [1:0]  RESP_OKAY    = 2'b00;
  localparam logic [1:0]  RESP_SLVERR  = 2'b10;
  typedef enum logic [2:0] {
    ACW_IDLE = 3'b001,
    ACW_MOVE = 3'b010,
    ACW_OPEN = 3'b100
  } acw_axis_t;
endpackage : acw_pkg

// ---- core/acw_feedback.sv ----
// Purpose: Turn a raw transducer count into a measured location
// Assumes: Raw count is a plain unsigned sample, one per cycle
// Notes:   Registered, one cycle of latency
module acw_feedback #(
  parameter int unsigned W = 24
) (
  input  wire logic          i_clk,
  input  wire logic          i_rst,
  input  wire logic [15:0]   i_cfg,
  input  wire logic [W-1:0]  i_raw,
  input  wire logic [W-1:0]  i_target,
  output logic      [W-1:0]  o_loc
);
  logic [3:0]   recirc;
  logic [W-1:0] corr;
  logic [W-1:0] scaled;
  logic [W-1:0] loc_next;

  assign recirc = i_cfg[acw_pkg::RECIRC_HI:acw_pkg::RECIRC_LO];

  always_comb begin
    corr = i_raw - W'(acw_pkg::RECIRC_COUNTS * recirc);
    case ({i_cfg[acw_pkg::DIV4_BIT], i_cfg[acw_pkg::DIV2_BIT]})
      2'b10:   scaled = {2'b00, corr[W-1:2]};
      2'b01:   scaled = {1'b0, corr[W-1:1]};
      2'b11:   scaled = {3'b000, corr[W-1:3]};
      default: scaled = corr;
    endcase
    // Simulation follows the target, ignoring the transducer
    loc_next = i_cfg[acw_pkg::SIM_BIT] ? i_target : scaled;
  end

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      o_loc <= '0;
    end else begin
      o_loc <= loc_next;
    end
  end
endmodule // acw_feedback

// ---- core/acw_integ.sv ----
// Purpose: Clamped integrator with windup flag
// Assumes: Full scale is 2^(W-1)-1
// Notes:   Clamp level picked by the integrator limit bit
module acw_integ #(
  parameter int unsigned W = 24
) (
  input  wire logic                i_clk,
  input  wire logic                i_rst,
  input  wire logic                i_clear,
  input  wire logic                i_hi_lim,
  input  wire logic signed [W-1:0] i_err,
  output logic signed      [W-1:0] o_acc,
  output logic                     o_windup
);
  localparam logic signed [W+1:0] FULL = (W+2)'((1 << (W-1)) - 1);
  logic signed [W+1:0] lim;
  logic signed [W+1:0] sum;

  always_comb begin
    lim = i_hi_lim ? (W+2)'((FULL * acw_pkg::ILIM_HI_PCT) / 100)
                   : (W+2)'((FULL * acw_pkg::ILIM_LO_PCT) / 100);
    sum = (W+2)'(o_acc) + (W+2)'(i_err);
  end

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      o_acc    <= '0;
      o_windup <= 1'b0;
    end else if (i_clear) begin
      o_acc    <= '0;
      o_windup <= 1'b0;
    end else if (sum > lim) begin
      o_acc    <= W'(lim);
      o_windup <= 1'b1;
    end else if (sum < -lim) begin
      o_acc    <= W'(-lim);
      o_windup <= 1'b1;
    end else begin
      o_acc    <= W'(sum);
      o_windup <= 1'b0;
    end
  end
endmodule // acw_integ

// ---- tb/acw_xdcr_model.sv ----
// Purpose: Transducer model feeding raw counts to the axis logic
// Assumes: Position is set by the bench, no motion dynamics
// Notes:   Gated mode adds the recirculation overrun the device removes
module acw_xdcr_model #(
  parameter int unsigned W = 24
) (
  input  wire logic         i_clk,
  input  wire logic         i_rst,
  input  wire logic [3:0]   i_recirc,
  input  wire logic [W-1:0] i_pos,
  output logic      [W-1:0] o_raw
);
  timeunit 1ns;
  timeprecision 1ps;

  // Counter keeps running between recirculations, so each one adds overrun
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      o_raw <= '0;
    end else begin
      o_raw <= i_pos + W'(i_recirc) * W'(acw_pkg::RECIRC_COUNTS);
    end
  end
endmodule // acw_xdcr_model

// ---- tb/axis_configuration_word_logic_bench.sv ----
// Purpose: Self-checking bench for the axis configuration word logic
// Assumes: One 25 MHz clock, host access over AXI4-Lite
// Notes:   Bready and rready stay high, so every answer is taken at once
module axis_configuration_word_logic_bench;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int unsigned W  = 24;
  localparam int          FS = 2 ** (W - 1) - 1;

  logic          i_clk = 1'b0;
  logic          i_rst = 1'b1;
  logic [W-1:0]  pos = '0;
  logic [W-1:0]  raw;
  logic [3:0]    recirc = 4'h0;
  logic          fault = 1'b0;
  logic          link = 1'b0;
  logic [W-1:0]  o_drive;
  logic          o_irq;
  logic [7:0]    s_axi_awaddr = 8'h00;
  logic          s_axi_awvalid = 1'b0;
  logic          s_axi_awready;
  logic [31:0]   s_axi_wdata = 32'h0;
  logic [3:0]    s_axi_wstrb = 4'hf;
  logic          s_axi_wvalid = 1'b0;
  logic          s_axi_wready;
  logic [1:0]    s_axi_bresp;
  logic          s_axi_bvalid;
  logic          s_axi_bready = 1'b1;
  logic [7:0]    s_axi_araddr = 8'h00;
  logic          s_axi_arvalid = 1'b0;
  logic          s_axi_arready;
  logic [31:0]   s_axi_rdata;
  logic [1:0]    s_axi_rresp;
  logic          s_axi_rvalid;
  logic          s_axi_rready = 1'b1;
  int            mismatches = 0;
  int            compares = 0;
  logic [15:0]   pc [5] = '{16'h0000, 16'h1004, 16'ha002, 16'hf006, 16'h0f80};
  int            ps [5] = '{0, 2, 1, 3, 0};

  always #20 i_clk = ~i_clk;

  acw_xdcr_model #(.W(W)) XDCR (.i_clk(i_clk), .i_rst(i_rst), .i_recirc(recirc),
    .i_pos(pos), .o_raw(raw));

  acw_axis #(.W(W)) DUT (.i_clk(i_clk), .i_rst(i_rst), .i_raw_count(raw),
    .i_xdcr_fault(fault), .i_link_lost(link), .o_drive(o_drive), .o_irq(o_irq),
    .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready));

  // ********************************
  // Bus and compare tasks
  // ********************************
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      mismatches++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    int n;
    bit aw;
    bit wd;
    n = 0;
    aw = 1'b1;
    wd = 1'b1;
    s_axi_awaddr  <= a;
    s_axi_wdata   <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid  <= 1'b1;
    while (aw || wd) begin
      @(posedge i_clk);
      n++;
      if (aw && s_axi_awready) begin
        aw = 1'b0;
        s_axi_awvalid <= 1'b0;
      end
      if (wd && s_axi_wready) begin
        wd = 1'b0;
        s_axi_wvalid <= 1'b0;
      end
    end
    do begin @(posedge i_clk); n++; end while (!s_axi_bvalid);
    check("write handshake", 32'(n >= 64), 32'h0);
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    int n;
    n = 0;
    s_axi_araddr  <= a;
    s_axi_arvalid <= 1'b1;
    do begin @(posedge i_clk); n++; end while (!s_axi_arready);
    s_axi_arvalid <= 1'b0;
    do begin @(posedge i_clk); n++; end while (!s_axi_rvalid);
    d = s_axi_rdata;
    r = s_axi_rresp;
    check("read handshake", 32'(n >= 64), 32'h0);
  endtask

  task automatic chk_rd(input string what, input logic [7:0] a, input logic [31:0] m,
                        input logic [31:0] exp);
    logic [31:0] d;
    logic [1:0]  r;
    rd(a, d, r);
    check(what, d & m, exp);
  endtask

  task automatic apply(input logic [15:0] c);
    wr(acw_pkg::OFF_CFG, {16'h0000, c});
    wr(acw_pkg::OFF_CMD, 32'h1);
  endtask

  task automatic go(input logic [W-1:0] t);
    wr(acw_pkg::OFF_TARGET, 32'(t));
    wr(acw_pkg::OFF_CMD, 32'h2);
    repeat (4) @(posedge i_clk);
  endtask

  task automatic end_of_test;
    $display("comparisons %0d mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  // ********************************
  // Tests
  // ********************************
  initial begin
    logic [31:0] d;
    logic [1:0]  r;
    repeat (8) @(posedge i_clk);
    i_rst <= 1'b0;
    @(posedge i_clk);
    chk_rd("staged config reset", acw_pkg::OFF_CFG, 32'hffff, 32'h0);
    wr(acw_pkg::OFF_CFG, 32'hffff);
    chk_rd("active before apply", acw_pkg::OFF_ACTIVE, 32'hffff, 32'h0);
    wr(acw_pkg::OFF_CMD, 32'h1);
    chk_rd("active after apply", acw_pkg::OFF_ACTIVE, 32'hffff, 32'hf07f);
    rd(8'h40, d, r);
    check("unmapped response", {30'h0, r}, {30'h0, acw_pkg::RESP_SLVERR});
    check("unmapped data", d, 32'h0);
    $display("test registers done");
    pos <= 24'd40000;
    for (int i = 0; i < 5; i++) begin
      recirc <= pc[i][15:12];
      apply(pc[i]);
      chk_rd("location", acw_pkg::OFF_POS, 32'hffffff, 32'(40000 >> ps[i]));
    end
    recirc <= 4'h0;
    $display("test prescale done");
    apply(16'h0000);
    wr(acw_pkg::OFF_IRQ_EN, 32'h8);
    fault <= 1'b1;
    // Event needs a cycle to reach the sticky bit before the read samples it
    repeat (2) @(posedge i_clk);
    chk_rd("fault status", acw_pkg::OFF_STATUS, 32'h8, 32'h8);
    check("irq raised", 32'(o_irq), 32'h1);
    wr(acw_pkg::OFF_IRQ_EN, 32'h0);
    chk_rd("enable readback", acw_pkg::OFF_IRQ_EN, 32'hf, 32'h0);
    check("irq masked", 32'(o_irq), 32'h0);
    wr(acw_pkg::OFF_IRQ_EN, 32'h8);
    fault <= 1'b0;
    wr(acw_pkg::OFF_IRQ_CLR, 32'h8);
    chk_rd("fault cleared", acw_pkg::OFF_STATUS, 32'h8, 32'h0);
    check("irq cleared", 32'(o_irq), 32'h0);
    fault <= 1'b1;
    apply(16'h0008);
    go(24'h001234);
    chk_rd("sim fault status", acw_pkg::OFF_STATUS, 32'h8, 32'h0);
    chk_rd("sim location", acw_pkg::OFF_POS, 32'hffffff, 32'h1234);
    check("sim drive", 32'(o_drive), 32'h0);
    fault <= 1'b0;
    wr(acw_pkg::OFF_IRQ_CLR, 32'hff);
    $display("test interrupt and simulate done");
    pos <= 24'd1000;
    apply(16'h0000);
    go(24'd1049576);
    check("drive positive", 32'(o_drive[W-1]), 32'h0);
    check("drive active", 32'(o_drive != '0), 32'h1);
    chk_rd("integrator low", acw_pkg::OFF_INTEG, 32'hffffff, 32'(FS * 20 / 100));
    chk_rd("windup flag", acw_pkg::OFF_STATUS, 32'h1, 32'h1);
    wr(acw_pkg::OFF_CMD, 32'h4);
    repeat (4) @(posedge i_clk);
    check("halted drive", 32'(o_drive), 32'h0);
    apply(16'h0041);
    go(24'd1049576);
    check("reversed drive", 32'(o_drive[W-1]), 32'h1);
    chk_rd("reported drive", acw_pkg::OFF_DRIVE, 32'h800000, 32'h0);
    chk_rd("integrator high", acw_pkg::OFF_INTEG, 32'hffffff, 32'(FS * 80 / 100));
    wr(acw_pkg::OFF_CMD, 32'h4);
    $display("test drive done");
    apply(16'h0020);
    chk_rd("abs apply open", acw_pkg::OFF_STATUS, 32'h40, 32'h40);
    check("abs apply null", 32'(o_drive), 32'h0);
    go(24'd500);
    check("abs never negative", 32'(o_drive[W-1]), 32'h0);
    wr(acw_pkg::OFF_CMD, 32'h4);
    go(24'd1000);
    chk_rd("abs done open", acw_pkg::OFF_STATUS, 32'h42, 32'h42);
    check("abs done null", 32'(o_drive), 32'h0);
    $display("test absolute done");
    apply(16'h0000);
    go(24'd1049576);
    link <= 1'b1;
    repeat (4) @(posedge i_clk);
    check("link loss halt", 32'(o_drive), 32'h0);
    chk_rd("link loss status", acw_pkg::OFF_STATUS, 32'h4, 32'h4);
    link <= 1'b0;
    apply(16'h0010);
    go(24'd1049576);
    link <= 1'b1;
    repeat (4) @(posedge i_clk);
    check("link loss continue", 32'(o_drive != '0), 32'h1);
    link <= 1'b0;
    wr(acw_pkg::OFF_CMD, 32'h4);
    $display("test link loss done");
    end_of_test();
  end

  initial begin
    repeat (20000) @(posedge i_clk);
    mismatches++;
    end_of_test();
  end
endmodule // axis_configuration_word_logic_bench
